// >>> dv/sfu_status_flags_test.sv
/*
 Self-checking bench of the status flag update block: random and corner
 instruction completions, register access over Avalon-MM, freeze.
 Assumes the design's package and header are compiled first.
*/
`timescale 1ns/1ps
module sfu_status_flags_test;
   import sfu_pkg::*;
   logic          i_clk_sys, i_sys_rst, i_instr_done;
   sfu_group_type i_group;
   logic          i_res_zero, i_res_skip, i_res_half_carry, i_res_carry;
   logic [7:0]    o_psw;
   logic [3:0]    i_avs_address, i_avs_byteenable;
   logic          i_avs_read, i_avs_write, o_avs_waitrequest;
   logic [31:0]   i_avs_writedata, o_avs_readdata, rd;
   logic [1:0]    o_avs_response, rs;
   logic [7:0]    e1, e2, p;
   logic [3:0]    r;
   int            error_cnt, tests_run;

   sfu_status_flags uut (
      .i_clk_sys        (i_clk_sys),
      .i_sys_rst        (i_sys_rst),
      .i_instr_done     (i_instr_done),
      .i_group          (i_group),
      .i_res_zero       (i_res_zero),
      .i_res_skip       (i_res_skip),
      .i_res_half_carry (i_res_half_carry),
      .i_res_carry      (i_res_carry),
      .o_psw            (o_psw),
      .i_avs_address    (i_avs_address),
      .i_avs_read       (i_avs_read),
      .i_avs_write      (i_avs_write),
      .i_avs_writedata  (i_avs_writedata),
      .i_avs_byteenable (i_avs_byteenable),
      .o_avs_readdata   (o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest),
      .o_avs_response   (o_avs_response)
   );

   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [7:0] nxt(logic [7:0] q, logic [3:0] g,
                                      logic [3:0] v);
      logic [7:0] n;
      n = q & 8'h51;
      case (g)
         4'h1: {n[6], n[4], n[0]} = {v[3], v[1], v[0]};
         4'h2: n[6] = v[3];
         4'h3, 4'h5: {n[6], n[5], n[4], n[0]} = v;
         4'h4: {n[6], n[5]} = v[3:2];
         4'h6: {n[6], n[5], n[4]} = v[3:1];
         4'h7: n[0] = v[0];
         4'h8: n[3] = 1'b1;
         4'h9: n[2] = 1'b1;
         default: ;
      endcase
      return n;
   endfunction

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_avs_read      <= ~wr;
      i_avs_write     <= wr;
      i_avs_address   <= a;
      i_avs_writedata <= d;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk("bus answer", 1, 0);
      rd = o_avs_readdata;
      rs = o_avs_response;
      i_avs_read  <= 1'b0;
      i_avs_write <= 1'b0;
   endtask

   task automatic instr(logic [3:0] g, logic [3:0] v);
      @(posedge i_clk_sys);
      i_instr_done <= 1'b1;
      i_group      <= sfu_group_type'(g);
      {i_res_zero, i_res_skip, i_res_half_carry, i_res_carry} <= v;
      @(posedge i_clk_sys);
      i_instr_done <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      error_cnt++;
      end_of_test();
   end

   initial begin
      {i_sys_rst, i_instr_done, i_avs_read, i_avs_write} = 4'h8;
      i_group = SFU_GRP_OTHER;
      {i_res_zero, i_res_skip, i_res_half_carry, i_res_carry} = 4'h0;
      i_avs_address = 4'h0;
      i_avs_writedata = 32'h0;
      i_avs_byteenable = 4'hf;
      error_cnt = 0;
      tests_run = 0;
      void'($urandom(32'h30ec3c25));
      repeat (10) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(posedge i_clk_sys);
      chk("reset psw", o_psw, 8'h00);
      chk("reset wait", o_avs_waitrequest, 1'b1);
      bus(1'b1, 4'h0, 32'hff);
      chk("psw write", o_psw, 8'h7d);
      bus(1'b0, 4'h0, 32'h0);
      chk("psw read", rd, 32'h7d);
      chk("psw resp", rs, 2'b00);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped resp", rs, 2'b11);
      chk("unmapped data", rd, 32'h0);
      bus(1'b1, 4'h1, 32'h0);
      chk("unmapped write", o_psw, 8'h7d);
      // Every group code, flags starting opposite to the results
      for (int g = 0; g < 16; g++) begin
         for (int v = 0; v < 2; v++) begin
            p = v ? 8'h00 : 8'hff;
            r = v ? 4'hf : 4'h0;
            bus(1'b1, 4'h0, {24'h0, p});
            instr(g[3:0], r);
            chk("group psw", o_psw, nxt(p, g[3:0], r));
            bus(1'b0, 4'h4, 32'h0);
            chk("last group", rd, g);
            bus(1'b0, 4'h8, 32'h0);
            chk("last results", rd, r);
         end
      end
      // Frozen flags ignore completions
      p = o_psw;
      bus(1'b1, 4'hc, 32'h1);
      bus(1'b0, 4'hc, 32'h0);
      chk("freeze read", rd, 32'h1);
      instr(4'h1, 4'hf);
      chk("frozen psw", o_psw, p);
      bus(1'b1, 4'hc, 32'h0);
      // Completion and software write in one cycle: completion wins
      p = o_psw;
      fork
         bus(1'b1, 4'h0, 32'h7d);
         instr(4'h7, 4'h0);
      join
      chk("write loses", o_psw, nxt(p, 4'h7, 4'h0));
      // Random back-to-back completions, one cycle per update
      e1 = o_psw;
      e2 = o_psw;
      repeat (600) begin
         @(posedge i_clk_sys);
         chk("random psw", o_psw, e2);
         e2 = e1;
         r = 4'($urandom);
         p = 8'($urandom_range(0, 15));
         i_instr_done <= p[0] | p[1];
         i_group <= sfu_group_type'(p[3:0] ^ {3'h0, p[0]});
         {i_res_zero, i_res_skip, i_res_half_carry, i_res_carry} <= r;
         if (p[0] | p[1]) e1 = nxt(e1, p[3:0] ^ {3'h0, p[0]}, r);
      end
      end_of_test();
   end
endmodule // sfu_status_flags_test

// >>> rtl/sfu_flag_next.sv
/*
 Combinational next-value logic of the status byte for one completed
 instruction. Assumes the decoder classifies the instruction group and
 the ALU supplies zero, skip, half-carry and carry results.
*/
`timescale 1ns/1ps
`include "sfu_params.svh"
module sfu_flag_next (
   // Present state and instruction
   input  wire logic [7:0]            i_psw,
   input  wire sfu_pkg::sfu_group_type i_group,
   // Results from the ALU
   input  wire logic                  i_res_zero,
   input  wire logic                  i_res_skip,
   input  wire logic                  i_res_half_carry,
   input  wire logic                  i_res_carry,
   // New status byte
   output logic [7:0]                 o_psw
);
   import sfu_pkg::*;

   always_comb begin
      // Default: skip and both chain flags clear, others kept
      o_psw = i_psw;
      o_psw[`SFU_BIT_SKIP_POS] = 1'b0;
      o_psw[`SFU_BIT_ACHAIN_POS] = 1'b0;
      o_psw[`SFU_BIT_LCHAIN_POS] = 1'b0;
      case (i_group)
         SFU_GRP_ARITH: begin
            o_psw[`SFU_BIT_ZERO_POS]  = i_res_zero;
            o_psw[`SFU_BIT_HALF_POS]  = i_res_half_carry;
            o_psw[`SFU_BIT_CARRY_POS] = i_res_carry;
         end
         SFU_GRP_LOGIC: begin
            o_psw[`SFU_BIT_ZERO_POS] = i_res_zero;
         end
         SFU_GRP_ARITH_SKIP, SFU_GRP_COMPARE_EQ: begin
            o_psw[`SFU_BIT_ZERO_POS]  = i_res_zero;
            o_psw[`SFU_BIT_SKIP_POS]  = i_res_skip;
            o_psw[`SFU_BIT_HALF_POS]  = i_res_half_carry;
            o_psw[`SFU_BIT_CARRY_POS] = i_res_carry;
         end
         SFU_GRP_TEST_BITS: begin
            o_psw[`SFU_BIT_ZERO_POS] = i_res_zero;
            o_psw[`SFU_BIT_SKIP_POS] = i_res_skip;
         end
         SFU_GRP_INC_DEC: begin
            o_psw[`SFU_BIT_ZERO_POS] = i_res_zero;
            o_psw[`SFU_BIT_SKIP_POS] = i_res_skip;
            o_psw[`SFU_BIT_HALF_POS] = i_res_half_carry;
         end
         SFU_GRP_ROTATE: begin
            o_psw[`SFU_BIT_CARRY_POS] = i_res_carry;
         end
         SFU_GRP_MOVI_ACCUM: begin
            o_psw[`SFU_BIT_ACHAIN_POS] = 1'b1;
         end
         SFU_GRP_MOVI_LOW: begin
            o_psw[`SFU_BIT_LCHAIN_POS] = 1'b1;
         end
         default: begin
         end
      endcase
      o_psw = o_psw & `SFU_FLAG_MASK;
   end
endmodule // sfu_flag_next

// >>> rtl/sfu_params.svh
/*
 Constants of the status flag update block: flag positions, reset
 values and register offsets. Included by the package and modules.
*/
`ifndef SFU_PARAMS_SVH
`define SFU_PARAMS_SVH
`define SFU_BIT_ZERO        3
`define SFU_BIT_ZERO_POS    6
`define SFU_BIT_SKIP_POS    5
`define SFU_BIT_HALF_POS    4
`define SFU_BIT_ACHAIN_POS  3
`define SFU_BIT_LCHAIN_POS  2
`define SFU_BIT_CARRY_POS   0
`define SFU_CTRL_FREEZE_POS 0
`define SFU_FLAG_MASK       8'h7d
`define SFU_PSW_RESET       8'h00
`define SFU_OFF_PSW         4'h0
`define SFU_OFF_GROUP       4'h4
`define SFU_OFF_ALU         4'h8
`define SFU_OFF_CTRL        4'hc
`define SFU_GROUP_W         4
`define SFU_RD_ZERO         32'h0000_0000
`endif

// >>> rtl/sfu_pkg.sv
/*
 Types of the status flag update block.
 Assumes sfu_params.svh is on the include path.
*/
`include "sfu_params.svh"
package sfu_pkg;
   typedef enum logic [`SFU_GROUP_W-1:0] {
      SFU_GRP_OTHER,
      SFU_GRP_ARITH,
      SFU_GRP_LOGIC,
      SFU_GRP_ARITH_SKIP,
      SFU_GRP_TEST_BITS,
      SFU_GRP_COMPARE_EQ,
      SFU_GRP_INC_DEC,
      SFU_GRP_ROTATE,
      SFU_GRP_MOVI_ACCUM,
      SFU_GRP_MOVI_LOW
   } sfu_group_type;
endpackage

// >>> rtl/sfu_status_flags.sv
/*
 Status flag update block: holds the status byte, updates it at each
 instruction completion and gives software access over Avalon-MM.
 Assumes one 40 MHz clock, a synchronous active-high reset, and a
 decoder that pulses i_instr_done once per completed instruction.
*/
// Decided for this implementation: the register addresses and register access over Avalon-MM.
// What this block does
// - Flags at D6, D5, D4, D3, D2, D0
// - Arithmetic sets zero, half-carry, carry; clears rest
// - Logic ops update zero only; keep carries
// - Skip arithmetic and magnitude compares set four flags
// - Bit tests set zero and skip only
// - Equality compares set four flags from subtraction
// - Rotates and shifts update carry only
// - Immediate loads set their own chain flag
// - Other instructions clear skip and chain flags
`timescale 1ns/1ps
`include "sfu_params.svh"
module sfu_status_flags (
   // Clock and reset
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_sys_rst,
   // Instruction completion from decoder and ALU
   input  wire logic                   i_instr_done,
   input  wire sfu_pkg::sfu_group_type i_group,
   input  wire logic                   i_res_zero,
   input  wire logic                   i_res_skip,
   input  wire logic                   i_res_half_carry,
   input  wire logic                   i_res_carry,
   // Status byte to the sequencer
   output logic [7:0]                  o_psw,
   // Avalon-MM slave
   input  wire logic [3:0]             i_avs_address,
   input  wire logic                   i_avs_read,
   input  wire logic                   i_avs_write,
   input  wire logic [31:0]            i_avs_writedata,
   input  wire logic [3:0]             i_avs_byteenable,
   output logic [31:0]                 o_avs_readdata,
   output logic                        o_avs_waitrequest,
   output logic [1:0]                  o_avs_response
);
   import sfu_pkg::*;

   logic [7:0]    psw_q;
   logic [7:0]    psw_next;
   sfu_group_type last_group_q;
   logic [3:0]    last_alu_q;
   logic          freeze_q;
   logic          acc_pend_q;
   logic [31:0]   rdata_d;
   logic          addr_ok;
   logic          wr_psw;

   // Decode of mapped word offsets
   function automatic logic sfu_mapped(input logic [3:0] a);
      if (a == `SFU_OFF_PSW) begin
         return 1'b1;
      end else if (a == `SFU_OFF_GROUP) begin
         return 1'b1;
      end else if (a == `SFU_OFF_ALU) begin
         return 1'b1;
      end else if (a == `SFU_OFF_CTRL) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

   sfu_flag_next u_next (
      .i_psw            (psw_q),
      .i_group          (i_group),
      .i_res_zero       (i_res_zero),
      .i_res_skip       (i_res_skip),
      .i_res_half_carry (i_res_half_carry),
      .i_res_carry      (i_res_carry),
      .o_psw            (psw_next)
   );

   // One-cycle accept: waitrequest high until a request is answered
   wire acc_req = (i_avs_read | i_avs_write) & ~acc_pend_q;
   assign addr_ok = sfu_mapped(i_avs_address);
   assign wr_psw  = acc_req & i_avs_write & i_avs_byteenable[0]
                    & (i_avs_address == `SFU_OFF_PSW);

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         acc_pend_q <= 1'b0;
      end else begin
         acc_pend_q <= acc_req;
      end
   end

   // Status byte; instruction update beats a software write
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         psw_q <= `SFU_PSW_RESET;
      end else if (i_instr_done && !freeze_q) begin
         psw_q <= psw_next;
      end else if (wr_psw) begin
         psw_q <= i_avs_writedata[7:0] & `SFU_FLAG_MASK;
      end
   end

   // Freeze control lets software hold the flags
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         freeze_q <= 1'b0;
      end else if (acc_req && i_avs_write && i_avs_byteenable[0]
                   && i_avs_address == `SFU_OFF_CTRL) begin
         freeze_q <= i_avs_writedata[`SFU_CTRL_FREEZE_POS];
      end
   end

   // Last completed instruction, visible to software
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         last_group_q <= SFU_GRP_OTHER;
         last_alu_q   <= 4'h0;
      end else if (i_instr_done) begin
         last_group_q <= i_group;
         last_alu_q   <= {i_res_zero, i_res_skip,
                          i_res_half_carry, i_res_carry};
      end
   end

   always_comb begin
      rdata_d = `SFU_RD_ZERO;
      if (i_avs_address == `SFU_OFF_PSW) begin
         rdata_d[7:0] = psw_q;
      end else if (i_avs_address == `SFU_OFF_GROUP) begin
         rdata_d[`SFU_GROUP_W-1:0] = last_group_q;
      end else if (i_avs_address == `SFU_OFF_ALU) begin
         rdata_d[3:0] = last_alu_q;
      end else if (i_avs_address == `SFU_OFF_CTRL) begin
         rdata_d[`SFU_CTRL_FREEZE_POS] = freeze_q;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_avs_readdata    <= `SFU_RD_ZERO;
         o_avs_waitrequest <= 1'b1;
         o_avs_response    <= 2'b00;
         o_psw             <= `SFU_PSW_RESET;
      end else begin
         o_avs_waitrequest <= ~acc_req;
         o_psw             <= (i_instr_done && !freeze_q) ? psw_next :
                              wr_psw ? (i_avs_writedata[7:0]
                                        & `SFU_FLAG_MASK) : psw_q;
         if (acc_req) begin
            o_avs_readdata <= i_avs_read ? rdata_d : `SFU_RD_ZERO;
            o_avs_response <= addr_ok ? 2'b00 : 2'b11;
         end
      end
   end

   // Assertions
   chk_psw_mirror: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) ##1 (o_psw == psw_q))
      else $error("status output differs from status byte");
   chk_reserved_zero: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) (psw_q[7] == 1'b0) && (psw_q[1] == 1'b0))
      else $error("reserved status bits set");
   chk_arith_update: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_ARITH) |=>
      psw_q == ({1'b0, $past(i_res_zero), 1'b0, $past(i_res_half_carry),
                 3'b000, $past(i_res_carry)}))
      else $error("arithmetic flags wrong");
   chk_logic_keep: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_LOGIC) |=>
      $stable({psw_q[4], psw_q[0]}) && psw_q[5:2] == {1'b0, psw_q[4], 2'b00})
      else $error("logic group disturbed carries");
   chk_cmp_skip: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && (i_group == SFU_GRP_ARITH_SKIP
       || i_group == SFU_GRP_COMPARE_EQ)) |=>
      psw_q[5] == $past(i_res_skip) && psw_q[0] == $past(i_res_carry))
      else $error("compare skip or carry wrong");
   chk_test_bits: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_TEST_BITS) |=>
      psw_q[6:5] == {$past(i_res_zero), $past(i_res_skip)}
      && $stable(psw_q[0]))
      else $error("bit test flags wrong");
   chk_incdec_cy: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_INC_DEC) |=>
      $stable(psw_q[0]) && psw_q[4] == $past(i_res_half_carry))
      else $error("increment touched carry");
   chk_rotate_cy: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_ROTATE) |=>
      psw_q[0] == $past(i_res_carry) && $stable(psw_q[6]) && !psw_q[5])
      else $error("rotate flags wrong");
   chk_chain_load: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_MOVI_ACCUM) |=>
      psw_q[5:2] == {1'b0, $past(psw_q[4]), 2'b10} && $stable(psw_q[6]))
      else $error("accumulator chain flag wrong");
   chk_low_chain: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_MOVI_LOW) |=>
      psw_q[5:2] == {1'b0, $past(psw_q[4]), 2'b01} && $stable(psw_q[6]))
      else $error("low chain flag wrong");
   chk_equal_flags: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_COMPARE_EQ) |=>
      psw_q == {1'b0, $past(i_res_zero), $past(i_res_skip),
                $past(i_res_half_carry), 3'b000, $past(i_res_carry)})
      else $error("equality compare flags wrong");
   chk_freeze_hold: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (freeze_q && !wr_psw) |=> $stable(psw_q))
      else $error("frozen flags changed");
   chk_bus_answer: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      acc_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer not one wait state");
   chk_other_clear: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst)
      (i_instr_done && !freeze_q && i_group == SFU_GRP_OTHER) |=>
      psw_q[5:2] == {1'b0, $past(psw_q[4]), 2'b00} && $stable(psw_q[6]))
      else $error("default group flags wrong");
endmodule // sfu_status_flags
